// ===== hw/cgsc_serial_ctrl.v
`timescale 1ns/1ps
`include "cgsc_defs.vh"
// Summary of operation
// R01 - Hardware mode picks CPU/PCI frequency from latched straps via sixteen-entry table
// R02 - Frequency register bit 3 picks straps (0) or software bits (1), reset zero
// R03 - Software index is bit 2 then bits 6,5,4, same table
// R04 - Latched mode strap: 0 makes shared pin halt input, 1 reference output
// R05 - In halt mode, halt input low holds CPU outputs low
// R06 - Four frequency straps sampled once after power up and held
// R07 - Power-down low stops all outputs after a full high period
// R08 - Each output or group enabled individually through serial registers; reference output has no register bit, only the mode strap
// R09 - Controller should wait 3 ms after power up before enabling outputs
// R10 - All control registers load defaults at power up
// R11 - Data moves only while clock low; start and stop are the exceptions
// R12 - Every unit is an eight-bit byte followed by acknowledge
// R13 - Write opens with start then address byte 1101 0010
// R14 - Command and count bytes follow; acknowledged and ignored
// R15 - Device acknowledges each received byte by pulling data low
// R16 - Data bytes go to registers 0,1,2 in order until stop
// R17 - Read address 1101 0011 returns registers from 0 sequentially until stop
// R18 - Enable bit 1 runs the output, 0 stops it
// R19 - Register 1 bits 3,1,0 gate memory, CPU pair, chipset; reset 1
// R20 - Register 2 bits 6,4..0 gate PCI 0,5,4,3,2,1; reset all ones
// R21 - Stop midway keeps fully received registers, later ones unchanged
// R22 - Enable changes take effect only while the clock is low
module cgsc_serial_ctrl #(
    parameter SETTLE_CYCLES = `CGSC_SETTLE_CYCLES
) (
    input  wire       i_clk,
    input  wire       i_rst,
    input  wire       i_serial_clock_line,
    input  wire       i_serial_data_line,
    output reg        o_serial_data_line,
    output reg        o_serial_data_line_oe,
    input  wire [3:0] i_hw_freq_strap,
    input  wire       i_mode_strap,
    input  wire       i_cpu_halt_n,
    input  wire       i_power_down_n,
    input  wire       i_cpu_src,
    input  wire       i_pci_src,
    input  wire       i_ref_src,
    input  wire       i_mem_src,
    output reg  [3:0] o_freq_index,
    output reg        o_ref_mode,
    output reg        o_settled,
    output wire       o_cpu_clk_true,
    output wire       o_cpu_clk_comp,
    output wire       o_chipset_cpu_clk,
    output wire       o_mem_clk_13th,
    output wire [5:0] o_pci_out,
    output wire       o_reference_out_a
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_ADDR  = 3'h1;
    localparam ST_WACK  = 3'h2;
    localparam ST_WDATA = 3'h3;
    localparam ST_RDATA = 3'h4;
    localparam ST_RACK  = 3'h5;
    localparam ST_SKIP  = 3'h6;

    reg  [1:0] scl_s;
    reg  [1:0] sda_s;
    reg  [1:0] pd_s;
    reg  [1:0] halt_s;
    reg  [3:0] strap_s0;
    reg  [3:0] strap_s1;
    reg        mode_s0;
    reg        mode_s1;
    reg        scl_q;
    reg        sda_q;
    reg        straps_taken;
    reg  [3:0] hw_strap;
    reg  [7:0] freq_select;
    reg  [7:0] cpu_clock_enables;
    reg  [7:0] pci_clock_enables;
    reg  [2:0] state;
    reg  [2:0] bit_cnt;
    reg  [7:0] shreg;
    reg  [1:0] byte_idx;
    reg  [1:0] reg_ptr;
    reg        is_read;
    reg  [3:0] next_freq_index;
    reg  [22:0] settle_cnt;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_cond;
    wire       stop_cond;
    wire       run;
    wire       cpu_run;
    wire [7:0] rd_byte;

    function [7:0] reg_read;
        input [1:0] idx;
        input [7:0] r0;
        input [7:0] r1;
        input [7:0] r2;
        begin
            case (idx)
                `CGSC_REG_FREQ:   reg_read = r0;
                `CGSC_REG_CPU_EN: reg_read = r1;
                `CGSC_REG_PCI_EN: reg_read = r2;
                default:          reg_read = 8'h00;
            endcase
        end
    endfunction

    // Pins pass two flops; the second stage feeds logic, and the serial lines add a third flop for edge detection
    always @(posedge i_clk) begin
        // Strap stages run through reset so the first edge after release sees the pins
        strap_s0 <= i_hw_freq_strap;
        strap_s1 <= strap_s0;
        mode_s0  <= i_mode_strap;
        mode_s1  <= mode_s0;
        if (i_rst) begin
            scl_s    <= 2'h3;
            sda_s    <= 2'h3;
            pd_s     <= 2'h3;
            halt_s   <= 2'h3;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
        end else begin
            scl_s    <= {scl_s[0], i_serial_clock_line};
            sda_s    <= {sda_s[0], i_serial_data_line};
            pd_s     <= {pd_s[0], i_power_down_n};
            halt_s   <= {halt_s[0], i_cpu_halt_n};
            scl_q    <= scl_s[1];
            sda_q    <= sda_s[1];
        end
    end

    assign scl_rise   = scl_s[1] & ~scl_q;
    assign scl_fall   = ~scl_s[1] & scl_q;
    assign start_cond = scl_s[1] & scl_q & sda_q & ~sda_s[1]; // R11
    assign stop_cond  = scl_s[1] & scl_q & ~sda_q & sda_s[1]; // R11

    // Straps caught once, on the first edge after reset release
    always @(posedge i_clk) begin
        if (i_rst) begin
            straps_taken <= 1'b0;
            hw_strap     <= 4'h0;
            o_ref_mode   <= 1'b0;
        end else if (!straps_taken) begin
            straps_taken <= 1'b1;
            hw_strap     <= strap_s1; // R06
            o_ref_mode   <= mode_s1; // R04
        end
    end

    // Advisory settle flag; enabling early is the controller's risk
    always @(posedge i_clk) begin
        if (i_rst) begin
            settle_cnt <= 23'h0;
            o_settled  <= 1'b0;
        end else if (settle_cnt < SETTLE_CYCLES[22:0]) begin
            settle_cnt <= settle_cnt + 23'h1;
        end else begin
            o_settled <= 1'b1; // R09
        end
    end

    always @* begin
        if (freq_select[`CGSC_FREQ_SW_BIT]) // R02
            next_freq_index = {freq_select[`CGSC_FREQ_SW_HI], freq_select[6:4]}; // R03
        else
            next_freq_index = hw_strap; // R01
    end

    always @(posedge i_clk) begin
        if (i_rst)
            o_freq_index <= 4'h0;
        else
            o_freq_index <= next_freq_index;
    end

    assign rd_byte = reg_read(reg_ptr, freq_select, cpu_clock_enables, pci_clock_enables);

    // Serial slave
    always @(posedge i_clk) begin
        if (i_rst) begin
            state                 <= ST_IDLE;
            bit_cnt               <= 3'h0;
            shreg                 <= 8'h00;
            byte_idx              <= 2'h0;
            reg_ptr               <= 2'h0;
            is_read               <= 1'b0;
            o_serial_data_line    <= 1'b0;
            o_serial_data_line_oe <= 1'b0;
            freq_select           <= `CGSC_FREQ_RESET; // R10
            cpu_clock_enables     <= `CGSC_CPU_EN_RESET; // R19
            pci_clock_enables     <= `CGSC_PCI_EN_RESET; // R20
        end else if (stop_cond) begin
            // Only whole bytes were committed, so nothing to undo here
            state                 <= ST_IDLE; // R21
            o_serial_data_line_oe <= 1'b0;
        end else if (start_cond) begin
            state                 <= ST_ADDR;
            bit_cnt               <= 3'h0;
            shreg                 <= 8'h00;
            byte_idx              <= 2'h0;
            reg_ptr               <= 2'h0;
            o_serial_data_line_oe <= 1'b0;
        end else begin
            case (state)
                ST_ADDR, ST_WDATA: begin
                    if (scl_rise) begin
                        shreg   <= {shreg[6:0], sda_s[1]};
                        bit_cnt <= bit_cnt + 3'h1; // R12
                    end
                    if (scl_fall && bit_cnt == 3'h0 && byte_idx == 2'h0 &&
                        state == ST_ADDR && shreg != 8'h00) begin
                        if (shreg == `CGSC_ADDR_WRITE || shreg == `CGSC_ADDR_READ) begin // R13
                            is_read               <= shreg[0];
                            o_serial_data_line    <= 1'b0;
                            o_serial_data_line_oe <= 1'b1; // R15
                            state                 <= ST_WACK;
                        end else begin
                            state <= ST_SKIP;
                        end
                    end else if (scl_fall && bit_cnt == 3'h0 && state == ST_WDATA) begin
                        if (byte_idx == 2'h3) begin
                            case (reg_ptr) // R16
                                `CGSC_REG_FREQ:
                                    freq_select <= shreg & `CGSC_FREQ_MASK;
                                `CGSC_REG_CPU_EN:
                                    cpu_clock_enables <= shreg & `CGSC_CPU_EN_MASK;
                                `CGSC_REG_PCI_EN:
                                    pci_clock_enables <= shreg; // R20
                                default: ;
                            endcase
                            if (reg_ptr != 2'h3)
                                reg_ptr <= reg_ptr + 2'h1;
                        end else begin
                            byte_idx <= byte_idx + 2'h1; // R14
                        end
                        o_serial_data_line    <= 1'b0;
                        o_serial_data_line_oe <= 1'b1; // R15
                        state                 <= ST_WACK;
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        o_serial_data_line_oe <= 1'b0;
                        shreg                 <= 8'h00;
                        if (is_read) begin
                            o_serial_data_line    <= 1'b0;
                            o_serial_data_line_oe <= ~rd_byte[7]; // R17
                            shreg                 <= rd_byte;
                            bit_cnt               <= 3'h0;
                            state                 <= ST_RDATA;
                        end else begin
                            if (byte_idx == 2'h0)
                                byte_idx <= 2'h1;
                            state <= ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (bit_cnt == 3'h7) begin
                            o_serial_data_line_oe <= 1'b0;
                            state                 <= ST_RACK;
                        end else begin
                            o_serial_data_line_oe <= ~shreg[6];
                            shreg                 <= {shreg[6:0], 1'b0};
                        end
                        bit_cnt <= bit_cnt + 3'h1;
                    end
                end
                ST_RACK: begin
                    // A controller nack ends the read; it then issues stop
                    if (scl_rise) begin
                        if (sda_s[1]) begin
                            state <= ST_SKIP;
                        end else begin
                            reg_ptr <= reg_ptr + 2'h1; // R17
                            is_read <= 1'b1;
                            state   <= ST_WACK;
                        end
                    end
                end
                ST_SKIP: ;
                default: state <= ST_IDLE;
            endcase
            if (state == ST_RACK && scl_rise && !sda_s[1])
                shreg <= 8'h00;
        end
    end

    assign run     = pd_s[1]; // R07
    assign cpu_run = run & (o_ref_mode | halt_s[1]); // R05

    cgsc_out_gate u_cpu_true (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_src (i_cpu_src),
        .i_en  (cpu_run & cpu_clock_enables[`CGSC_CPU_PAIR_BIT]), // R19 R18
        .o_clk (o_cpu_clk_true)
    );
    cgsc_out_gate u_cpu_comp (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_src (~i_cpu_src),
        .i_en  (cpu_run & cpu_clock_enables[`CGSC_CPU_PAIR_BIT]),
        .o_clk (o_cpu_clk_comp)
    );
    cgsc_out_gate u_cpu_chip (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_src (i_cpu_src),
        .i_en  (cpu_run & cpu_clock_enables[`CGSC_CPU_CHIP_BIT]), // R08
        .o_clk (o_chipset_cpu_clk)
    );
    cgsc_out_gate u_mem (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_src (i_mem_src),
        .i_en  (run & cpu_clock_enables[`CGSC_CPU_MEM13_BIT]),
        .o_clk (o_mem_clk_13th)
    );
    cgsc_out_gate u_ref (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_src (i_ref_src),
        .i_en  (run & o_ref_mode), // R04
        .o_clk (o_reference_out_a)
    );
    cgsc_out_gate u_pci0 (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_src (i_pci_src),
        .i_en  (run & pci_clock_enables[6]), // R20
        .o_clk (o_pci_out[0])
    );
    cgsc_out_gate u_pci1 (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_src (i_pci_src),
        .i_en  (run & pci_clock_enables[0]),
        .o_clk (o_pci_out[1])
    );
    cgsc_out_gate u_pci2 (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_src (i_pci_src),
        .i_en  (run & pci_clock_enables[1]),
        .o_clk (o_pci_out[2])
    );
    cgsc_out_gate u_pci3 (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_src (i_pci_src),
        .i_en  (run & pci_clock_enables[2]),
        .o_clk (o_pci_out[3])
    );
    cgsc_out_gate u_pci4 (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_src (i_pci_src),
        .i_en  (run & pci_clock_enables[3]),
        .o_clk (o_pci_out[4])
    );
    cgsc_out_gate u_pci5 (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_src (i_pci_src),
        .i_en  (run & pci_clock_enables[4]),
        .o_clk (o_pci_out[5])
    );
endmodule // cgsc_serial_ctrl

// ===== pkg/cgsc_defs.vh
`ifndef CGSC_DEFS_VH
`define CGSC_DEFS_VH
`define CGSC_REG_FREQ       2'h0
`define CGSC_REG_CPU_EN     2'h1
`define CGSC_REG_PCI_EN     2'h2
`define CGSC_NUM_REGS       3
`define CGSC_FREQ_RESET     8'h00
`define CGSC_CPU_EN_RESET   8'h0b
`define CGSC_CPU_EN_MASK    8'h0b
`define CGSC_PCI_EN_RESET   8'hff
`define CGSC_FREQ_SW_BIT    3
`define CGSC_FREQ_SW_HI     2
`define CGSC_FREQ_MASK      8'h7c
`define CGSC_CPU_MEM13_BIT  3
`define CGSC_CPU_PAIR_BIT   1
`define CGSC_CPU_CHIP_BIT   0
`define CGSC_ADDR_WRITE     8'hd2
`define CGSC_ADDR_READ      8'hd3
`define CGSC_SETTLE_MS      3
`define CGSC_CLK_MHZ        50
`define CGSC_SETTLE_CYCLES  (`CGSC_SETTLE_MS * `CGSC_CLK_MHZ * 1000)
`endif

// ===== hw/cgsc_out_gate.v
`timescale 1ns/1ps
`include "cgsc_defs.vh"
// Glitch-free gate: the enable is only taken while the clock is low
// Source is synchronised first, so the gate adds three cycles of lag
module cgsc_out_gate (
    input  wire i_clk,
    input  wire i_rst,
    input  wire i_src,
    input  wire i_en,
    output reg  o_clk
);
    reg src_s;
    reg src_d;
    reg en_lat;
    always @(posedge i_clk) begin
        if (i_rst) begin
            src_s  <= 1'b0;
            src_d  <= 1'b0;
            en_lat <= 1'b0;
            o_clk  <= 1'b0;
        end else begin
            src_s <= i_src;
            src_d <= src_s;
            if (!src_d)
                en_lat <= i_en; // R22 R07
            o_clk <= src_d & en_lat;
        end
    end
endmodule // cgsc_out_gate

// ===== tb/cgsc_serial_ctrl_asserts.sv
`timescale 1ns/1ps
module cgsc_chk (
    input wire       i_clk,
    input wire       i_rst,
    input wire       i_serial_clock_line,
    input wire       i_cpu_halt_n,
    input wire       i_power_down_n,
    input wire       i_pci_src,
    input wire       o_serial_data_line,
    input wire       o_serial_data_line_oe,
    input wire       o_ref_mode,
    input wire       o_settled,
    input wire       o_cpu_clk_true,
    input wire       o_cpu_clk_comp,
    input wire       o_chipset_cpu_clk,
    input wire       o_mem_clk_13th,
    input wire [5:0] o_pci_out,
    input wire       o_reference_out_a
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire cpu_any = o_cpu_clk_true | o_cpu_clk_comp | o_chipset_cpu_clk;
    wire all_any = cpu_any | o_mem_clk_13th | o_reference_out_a | (|o_pci_out);
    property p_od_zero; !o_serial_data_line; endproperty
    a_od_zero: assert property (p_od_zero) else $error("data pin value high");
    property p_sda_low;
        $changed(o_serial_data_line_oe) |-> !i_serial_clock_line && !$past(i_serial_clock_line);
    endproperty
    a_sda_low: assert property (p_sda_low) else $error("data moved with clock high");
    property p_ack_hold; $rose(o_serial_data_line_oe) |=> o_serial_data_line_oe [*4]; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("data pull too short");
    // Ten cycles covers sync plus the last full high period
    property p_pd_stop; (!i_power_down_n) [*8] ##1 !i_power_down_n |=> !all_any; endproperty
    a_pd_stop: assert property (p_pd_stop) else $error("output runs in power down");
    property p_halt; (!o_ref_mode && !i_cpu_halt_n) [*8] ##1 !i_cpu_halt_n |=> !cpu_any;
    endproperty
    a_halt: assert property (p_halt) else $error("cpu output runs while halted");
    property p_ref_halt; (!o_ref_mode) [*4] |=> !o_reference_out_a; endproperty
    a_ref_halt: assert property (p_ref_halt) else $error("reference runs in halt mode");
    property p_mode_held; o_settled |-> $stable(o_ref_mode); endproperty
    a_mode_held: assert property (p_mode_held) else $error("mode strap not held");
    property p_gate_rise; $rose(o_pci_out[0]) |-> $past(i_pci_src, 3); endproperty
    a_gate_rise: assert property (p_gate_rise) else $error("output rose off source");
    property p_gate_fall; $fell(o_pci_out[0]) |-> !$past(i_pci_src, 3); endproperty
    a_gate_fall: assert property (p_gate_fall) else $error("output high cut short");
endmodule // cgsc_chk
bind cgsc_serial_ctrl cgsc_chk u_cgsc_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_serial_clock_line(i_serial_clock_line),
    .i_cpu_halt_n(i_cpu_halt_n), .i_power_down_n(i_power_down_n), .i_pci_src(i_pci_src),
    .o_serial_data_line(o_serial_data_line), .o_serial_data_line_oe(o_serial_data_line_oe),
    .o_ref_mode(o_ref_mode), .o_settled(o_settled), .o_cpu_clk_true(o_cpu_clk_true),
    .o_cpu_clk_comp(o_cpu_clk_comp), .o_chipset_cpu_clk(o_chipset_cpu_clk),
    .o_mem_clk_13th(o_mem_clk_13th), .o_pci_out(o_pci_out),
    .o_reference_out_a(o_reference_out_a));

// ===== tb/cgsc_mst.sv
`timescale 1ns/1ps
// Two-wire controller; eight clocks a bit gives the 160 ns link period
module cgsc_mst (
    input  wire i_clk,
    input  wire i_sda,
    output reg  o_scl,
    output reg  o_sda_oe
);
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    task wt(input integer n);
        repeat (n) @(posedge i_clk);
    endtask
    task bit_x(input b, output r);
        begin
            o_scl <= 1'b0;
            wt(2);
            o_sda_oe <= ~b;
            wt(2);
            o_scl <= 1'b1;
            wt(2);
            r = i_sda;
            wt(2);
        end
    endtask
    task start;
        begin
            o_scl <= 1'b1;
            wt(4);
            o_sda_oe <= 1'b1;
            wt(4);
        end
    endtask
    task stop;
        begin
            o_scl <= 1'b0;
            wt(2);
            o_sda_oe <= 1'b1;
            wt(2);
            o_scl <= 1'b1;
            wt(4);
            o_sda_oe <= 1'b0;
            wt(4);
        end
    endtask
    task wbyte(input [7:0] d, output ack);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1) bit_x(d[i], r);
            bit_x(1'b1, r);
            ack = ~r;
        end
    endtask
    task rbyte(input mack, output [7:0] d);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1) bit_x(1'b1, d[i]);
            bit_x(~mack, r);
        end
    endtask
endmodule // cgsc_mst

// ===== tb/cgsc_serial_ctrl_test.sv
`timescale 1ns/1ps
module cgsc_serial_ctrl_test;
    reg         i_clk = 1'b0;
    reg         i_rst = 1'b1;
    reg  [3:0]  strap = 4'ha;
    reg         halt_n = 1'b1;
    reg         mode = 1'b0;
    wire        settled;
    reg         pd_n = 1'b1;
    reg         src = 1'b0;
    wire        scl;
    wire        m_oe;
    wire        d_oe;
    wire        d_val;
    wire        sda = ~(m_oe | d_oe);
    wire [3:0]  idx;
    wire        ref_mode;
    wire [10:0] outs;
    integer     miscompares = 0;
    integer     tests_run = 0;
    integer     cyc = 0;
    reg  [7:0]  rd;
    reg         ack;
    always #10 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc % 4 == 3) src <= ~src;
        if (cyc == 30000) begin
            miscompares = miscompares + 1;
            give_verdict;
        end
    end
    cgsc_serial_ctrl #(.SETTLE_CYCLES(20)) u_cgsc_serial_ctrl (
        .i_clk(i_clk), .i_rst(i_rst), .i_serial_clock_line(scl),
        .i_serial_data_line(sda), .o_serial_data_line(d_val),
        .o_serial_data_line_oe(d_oe), .i_hw_freq_strap(strap), .i_mode_strap(mode),
        .i_cpu_halt_n(halt_n), .i_power_down_n(pd_n), .i_cpu_src(src),
        .i_pci_src(src), .i_ref_src(src), .i_mem_src(src), .o_freq_index(idx),
        .o_ref_mode(ref_mode), .o_settled(settled), .o_cpu_clk_true(outs[0]),
        .o_cpu_clk_comp(outs[1]), .o_chipset_cpu_clk(outs[2]), .o_mem_clk_13th(outs[3]),
        .o_pci_out(outs[10:5]), .o_reference_out_a(outs[4]));
    cgsc_mst u_cgsc_mst (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
    task chk(input string nm, input [10:0] exp, input [10:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("BAD %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task wr(input [23:0] d, input integer n);
        integer i;
        begin
            u_cgsc_mst.start;
            u_cgsc_mst.wbyte(8'hd2, ack);
            chk("write addr ack", 1, ack);
            u_cgsc_mst.wbyte(8'ha5, ack);
            chk("command ack", 1, ack);
            u_cgsc_mst.wbyte(8'h5a, ack);
            chk("count ack", 1, ack);
            for (i = 0; i < n; i = i + 1) begin
                u_cgsc_mst.wbyte(d[23-8*i -: 8], ack);
                chk("data ack", 1, ack);
            end
            u_cgsc_mst.stop;
        end
    endtask
    // Reads registers 0 to 3, the last one beyond the map
    task rd4(input [31:0] exp);
        integer i;
        begin
            u_cgsc_mst.start;
            u_cgsc_mst.wbyte(8'hd3, ack);
            chk("read addr ack", 1, ack);
            for (i = 0; i < 4; i = i + 1) begin
                u_cgsc_mst.rbyte(i < 3, rd);
                chk("read byte", exp[31-8*i -: 8], rd);
            end
            u_cgsc_mst.stop;
        end
    endtask
    task act(input string nm, input [10:0] exp);
        reg [10:0] seen;
        begin
            seen = 0;
            repeat (12) @(posedge i_clk);
            repeat (32) begin
                @(posedge i_clk);
                seen = seen | outs;
            end
            chk(nm, exp, seen);
        end
    endtask
    task s_reset;
        begin
            rd4(32'h000bff00);
            chk("hw index", 4'ha, idx);
            chk("mode", 0, ref_mode);
            chk("settled", 1, settled);
            act("reset outputs", 11'h7ef);
        end
    endtask
    task s_soft;
        begin
            wr({8'h7f, 8'hff, 8'h41}, 3);
            rd4(32'h7c0b4100);
            chk("sw index", 4'hf, idx);
            act("pci gating", 11'h06f);
            halt_n <= 1'b0;
            act("halted", 11'h068);
            halt_n <= 1'b1;
            // Stop after register 1 leaves register 2 alone
            wr({8'h0c, 8'h00, 8'h00}, 2);
            rd4(32'h0c004100);
            chk("sw msb", 4'h8, idx);
            act("cpu stopped", 11'h060);
        end
    endtask
    task s_hw;
        begin
            strap <= 4'h3;
            wr({8'h00, 8'h00, 8'h00}, 1);
            chk("held strap", 4'ha, idx);
        end
    endtask
    task s_misc;
        begin
            u_cgsc_mst.start;
            u_cgsc_mst.wbyte(8'ha0, ack);
            chk("foreign addr", 0, ack);
            u_cgsc_mst.stop;
            // A refused address must not spoil the next start
            rd4(32'h00004100);
            pd_n <= 1'b0;
            act("power down", 11'h000);
            pd_n <= 1'b1;
            act("power up", 11'h060);
        end
    endtask
    // Second power up with the reference mode strapped and new frequency straps
    task s_mode;
        begin
            mode <= 1'b1;
            i_rst <= 1'b1;
            repeat (20) @(posedge i_clk);
            i_rst <= 1'b0;
            repeat (5) @(posedge i_clk);
            chk("settle early", 0, settled);
            chk("new strap", 4'h3, idx);
            chk("ref mode", 1, ref_mode);
            repeat (25) @(posedge i_clk);
            chk("settle late", 1, settled);
            rd4(32'h000bff00);
            halt_n <= 1'b0;
            act("ref mode run", 11'h7ff);
            halt_n <= 1'b1;
        end
    endtask
    task give_verdict;
        begin
            if (miscompares == 0 && tests_run > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (30) @(posedge i_clk);
        s_reset;
        s_soft;
        s_hw;
        s_misc;
        s_mode;
        give_verdict;
    end
endmodule // cgsc_serial_ctrl_test
